// ==== design/qwp_defines.svh ====
`ifndef QWP_DEFINES_SVH
`define QWP_DEFINES_SVH

// Geometry
`define QWP_NUM_CH 4
`define QWP_NUM_SAVED 16
`define QWP_POS_W 6
`define QWP_TAPS 64
`define QWP_POS_MAX 6'h3f
`define QWP_POS_MIN 6'h00
`define QWP_POS_RST 6'h00
`define QWP_SAVED_RST 6'h00

// Target address: fixed upper bits, straps in the low four
`define QWP_ADDR_PREFIX 3'h2

// Instruction byte: opcode [7:4], channel [3:2], saved slot [1:0]
`define QWP_OP_RD_WIPER 4'h9
`define QWP_OP_WR_WIPER 4'ha
`define QWP_OP_RD_SAVED 4'hb
`define QWP_OP_WR_SAVED 4'hc
`define QWP_OP_RECALL 4'hd
`define QWP_OP_STORE 4'he
`define QWP_OP_INCDEC 4'h2

// Data byte bit that chooses the step direction in inc/dec mode
`define QWP_STEP_UP_BIT 0

`endif

// ==== design/qwp_pkg.sv ====
package qwp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } qwp_state_e;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_INSTR,
    PH_DATA
  } qwp_phase_e;

  typedef logic [5:0] qwp_pos_t;
  typedef logic [23:0] qwp_pos_bus_t;
  typedef logic [255:0] qwp_tap_bus_t;

endpackage

// ==== design/qwp_sync.sv ====
`timescale 1ns/1ps
module qwp_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  import qwp_pkg::*;

  // Reset high: bus lines idle high, so no false edge at release
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '1;
      sync_r <= '1;
      last_r <= '1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~last_r;
  assign fall_o = ~sync_r & last_r;

endmodule

// ==== design/qwp_tap_decode.sv ====
`timescale 1ns/1ps
`include "qwp_defines.svh"
module qwp_tap_decode (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire qwp_pkg::qwp_pos_bus_t pos_i,
  output qwp_pkg::qwp_tap_bus_t tap_o
);
  import qwp_pkg::*;

  genvar ch;
  generate
    for (ch = 0; ch < `QWP_NUM_CH; ch++) begin : g_ch
      logic [`QWP_TAPS-1:0] tap_r;
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          tap_r <= 64'h1;
        end else begin
          tap_r <= 64'h1 << pos_i[ch*`QWP_POS_W +: `QWP_POS_W]; // R5
        end
      end
      assign tap_o[ch*`QWP_TAPS +: `QWP_TAPS] = tap_r;
    end
  endgenerate

endmodule

// ==== design/qwp_quad_wiper.sv ====
// Notes on behaviour
// (R1) Four 6-bit wiper position registers, independent.
// (R2) Sixteen 6-bit saved settings, four per channel.
// (R3) Power-up copies first saved setting into wiper.
// (R4) Answer only when address matches strap pins.
// (R5) Exactly one tap per channel, set by wiper.
// (R6) Wiper and saved registers readable and writable.
// (R7) Instructions copy between wiper and saved settings.
// (R8) Increment/decrement mode steps the wiper.
// (R9) Data line only pulls low or releases.
// (R10) Controller clock times every transfer.
// (R11) Steps are one tap, saturating at 0/63.
`timescale 1ns/1ps
`include "qwp_defines.svh"
module qwp_quad_wiper (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [3:0] strap_address_pins_i,
  output qwp_pkg::qwp_pos_bus_t wiper_pos_o,
  output qwp_pkg::qwp_tap_bus_t wiper_tap_o
);
  import qwp_pkg::*;

  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;

  // Bus clock is only sampled; its edges pace the whole protocol
  qwp_sync #(.W(6)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i({strap_address_pins_i, sda_i, scl_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [3:0] strap_s;

  assign scl_s = pin_lvl[0];
  assign sda_s = pin_lvl[1];
  assign strap_s = pin_lvl[5:2];
  assign scl_rise = pin_rise[0]; // R10
  assign scl_fall = pin_fall[0]; // R10
  assign start_det = pin_fall[1] & scl_s;
  assign stop_det = pin_rise[1] & scl_s;

  qwp_state_e state_r;
  qwp_phase_e phase_r;
  logic [7:0] shift_r;
  logic [2:0] bitcnt_r;
  logic done_r;
  logic acc_r;
  logic rw_r;
  logic nack_r;
  logic sda_oe_r;
  logic [3:0] op_r;
  logic [1:0] ptr_ch_r;
  logic [1:0] ptr_slot_r;
  logic boot_r;
  logic [3:0][5:0] wiper_r;
  logic [15:0][5:0] saved_r;
  wire [3:0][5:0] wiper_nxt;
  wire [15:0][5:0] saved_nxt;

  logic [7:0] byte_nxt;
  logic [3:0] op_in;
  logic last_bit;
  logic addr_hit;
  logic op_ok;
  logic data_ok;
  logic instr_exec;
  logic data_exec;
  logic accept;
  logic [7:0] tx_byte;

  assign byte_nxt = {shift_r[6:0], sda_s};
  assign op_in = byte_nxt[7:4];
  assign last_bit = (state_r == ST_RX) && scl_rise && (bitcnt_r == 3'h7) && !done_r;
  assign addr_hit = byte_nxt[7:1] == {`QWP_ADDR_PREFIX, strap_s}; // R4
  assign op_ok = (op_in == `QWP_OP_RD_WIPER) || (op_in == `QWP_OP_WR_WIPER) ||
                 (op_in == `QWP_OP_RD_SAVED) || (op_in == `QWP_OP_WR_SAVED) ||
                 (op_in == `QWP_OP_RECALL) || (op_in == `QWP_OP_STORE) ||
                 (op_in == `QWP_OP_INCDEC);
  // Data bytes only make sense after a write or step instruction
  assign data_ok = (op_r == `QWP_OP_WR_WIPER) || (op_r == `QWP_OP_WR_SAVED) || (op_r == `QWP_OP_INCDEC);
  assign instr_exec = last_bit && (phase_r == PH_INSTR) && op_ok;
  assign data_exec = last_bit && (phase_r == PH_DATA) && data_ok;
  assign accept = (phase_r == PH_ADDR) ? addr_hit : (phase_r == PH_INSTR) ? op_ok : data_ok;
  assign tx_byte = ((op_r == `QWP_OP_RD_SAVED) || (op_r == `QWP_OP_WR_SAVED)) ?
                   {2'h0, saved_r[{ptr_ch_r, ptr_slot_r}]} : {2'h0, wiper_r[ptr_ch_r]}; // R6

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      phase_r <= PH_ADDR;
      shift_r <= 8'h00;
      bitcnt_r <= 3'h0;
      done_r <= 1'b0;
      acc_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_RX;
      phase_r <= PH_ADDR;
      bitcnt_r <= 3'h0;
      done_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (scl_rise && !done_r) begin // R10
            shift_r <= byte_nxt;
            bitcnt_r <= bitcnt_r + 3'h1;
            if (bitcnt_r == 3'h7) begin
              done_r <= 1'b1;
              acc_r <= accept;
              if (phase_r == PH_ADDR) begin
                rw_r <= sda_s;
              end
            end
          end else if (scl_fall && done_r) begin
            done_r <= 1'b0;
            bitcnt_r <= 3'h0;
            if (acc_r) begin
              state_r <= ST_ACK;
              sda_oe_r <= 1'b1;
            end else begin
              // Foreign address or bad byte: stay off the line till next start
              state_r <= ST_IDLE; // R4
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (phase_r == PH_ADDR && rw_r) begin
              state_r <= ST_TX;
              shift_r <= tx_byte;
              sda_oe_r <= ~tx_byte[7]; // R9
              nack_r <= 1'b0;
            end else begin
              state_r <= ST_RX;
              sda_oe_r <= 1'b0;
              phase_r <= (phase_r == PH_ADDR) ? PH_INSTR : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_r == 3'h7) begin
              state_r <= ST_TXACK;
              sda_oe_r <= 1'b0;
              bitcnt_r <= 3'h0;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe_r <= ~shift_r[6]; // R9
              bitcnt_r <= bitcnt_r + 3'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_TX;
              shift_r <= tx_byte;
              sda_oe_r <= ~tx_byte[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_r <= `QWP_OP_RD_WIPER;
      ptr_ch_r <= 2'h0;
      ptr_slot_r <= 2'h0;
    end else if (instr_exec) begin
      op_r <= op_in;
      ptr_ch_r <= byte_nxt[3:2];
      ptr_slot_r <= byte_nxt[1:0];
    end
  end

  genvar ch, e;
  generate
    for (ch = 0; ch < `QWP_NUM_CH; ch++) begin : g_wiper
      logic sel;
      logic wr;
      logic rc;
      logic step;
      logic [5:0] cur;
      logic [5:0] stepped;
      assign cur = wiper_r[ch];
      assign sel = ptr_ch_r == 2'(ch);
      assign wr = data_exec && (op_r == `QWP_OP_WR_WIPER) && sel; // R6
      assign rc = instr_exec && (op_in == `QWP_OP_RECALL) && (byte_nxt[3:2] == 2'(ch)); // R7
      assign step = data_exec && (op_r == `QWP_OP_INCDEC) && sel; // R8
      // Saturate rather than wrap so a runaway step never jumps end to end
      assign stepped = byte_nxt[`QWP_STEP_UP_BIT] ?
                       ((cur == `QWP_POS_MAX) ? cur : cur + 6'h01) :
                       ((cur == `QWP_POS_MIN) ? cur : cur - 6'h01); // R11
      assign wiper_nxt[ch] = boot_r ? saved_r[4*ch] : // R3
                             rc ? saved_r[byte_nxt[3:0]] :
                             wr ? byte_nxt[5:0] :
                             step ? stepped : cur; // R1
    end
    for (e = 0; e < `QWP_NUM_SAVED; e++) begin : g_saved
      logic wr;
      logic st;
      assign wr = data_exec && (op_r == `QWP_OP_WR_SAVED) && ({ptr_ch_r, ptr_slot_r} == 4'(e)); // R6
      assign st = instr_exec && (op_in == `QWP_OP_STORE) && (byte_nxt[3:0] == 4'(e)); // R7
      assign saved_nxt[e] = st ? wiper_r[e/4] : wr ? byte_nxt[5:0] : saved_r[e]; // R2
    end
  endgenerate

  // Saved settings model non-volatile cells; reset stands in for their content
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      saved_r <= {16{`QWP_SAVED_RST}};
    end else begin
      saved_r <= saved_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_r <= 1'b1;
      wiper_r <= {4{`QWP_POS_RST}};
    end else begin
      boot_r <= 1'b0;
      wiper_r <= wiper_nxt;
    end
  end

  qwp_tap_decode u_taps (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .pos_i(wiper_r),
    .tap_o(wiper_tap_o)
  );

  assign sda_o = 1'b0; // R9
  assign sda_oe_o = sda_oe_r;
  assign wiper_pos_o = wiper_r;

  // Helper history for the checks below
  logic [3:0][5:0] wiper_q;
  logic [1:0] ptr_q;
  logic [7:0] byte_q;
  logic ev_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wiper_q <= {4{`QWP_POS_RST}};
      ptr_q <= 2'h0;
      byte_q <= 8'h00;
      ev_q <= 1'b0;
    end else begin
      wiper_q <= wiper_r;
      ptr_q <= ptr_ch_r;
      byte_q <= byte_nxt;
      ev_q <= scl_fall || start_det || stop_det;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_step_mid;
    data_exec && (op_r == `QWP_OP_INCDEC) && (wiper_r[ptr_ch_r] != `QWP_POS_MAX) &&
      (wiper_r[ptr_ch_r] != `QWP_POS_MIN);
  endsequence
  sequence s_step_edge;
    data_exec && (op_r == `QWP_OP_INCDEC) &&
      ((byte_nxt[0] && wiper_r[ptr_ch_r] == `QWP_POS_MAX) || (!byte_nxt[0] && wiper_r[ptr_ch_r] == `QWP_POS_MIN));
  endsequence
  sequence s_read_start;
    (state_r == ST_ACK) && (phase_r == PH_ADDR) && rw_r && scl_fall && !start_det && !stop_det;
  endsequence

  wiper_hold_a: assert property (!(boot_r || instr_exec || data_exec) |=> wiper_r == wiper_q) // R1
    else $error("wiper changed without cause");
  saved_hold_a: assert property (!(instr_exec || data_exec) |=> $stable(saved_r)) // R2
    else $error("saved setting changed without cause");
  boot_recall_a: assert property (boot_r |=> wiper_r == {saved_r[12], saved_r[8], saved_r[4], saved_r[0]}) // R3
    else $error("power-up recall missing");
  addr_miss_a: assert property (last_bit && phase_r == PH_ADDR && !addr_hit && !stop_det |=> !sda_oe_r [*8]) // R4
    else $error("answered a foreign address");
  tap_follow_a: assert property (wiper_tap_o[63:0] == (64'h1 << wiper_q[0]) && // R5
      wiper_tap_o[127:64] == (64'h1 << wiper_q[1]) && wiper_tap_o[191:128] == (64'h1 << wiper_q[2]) &&
      wiper_tap_o[255:192] == (64'h1 << wiper_q[3]))
    else $error("tap select does not follow wiper");
  wr_wiper_a: assert property (data_exec && op_r == `QWP_OP_WR_WIPER |=> wiper_r[ptr_q] == byte_q[5:0]) // R6
    else $error("wiper write lost");
  read_out_a: assert property (s_read_start |=> state_r == ST_TX && sda_oe_r == !shift_r[7]) // R6
    else $error("read data first bit wrong");
  store_a: assert property (instr_exec && op_in == `QWP_OP_STORE |=> // R7
      saved_r[byte_q[3:0]] == wiper_q[byte_q[3:2]])
    else $error("store to saved setting failed");
  step_a: assert property (s_step_mid |=> // R8
      wiper_r[ptr_q] == (byte_q[0] ? wiper_q[ptr_q] + 6'h01 : wiper_q[ptr_q] - 6'h01))
    else $error("step not one tap");
  sat_a: assert property (s_step_edge |=> wiper_r[ptr_q] == wiper_q[ptr_q]) // R11
    else $error("step wrapped at an end");
  sda_edge_a: assert property ($changed(sda_oe_r) |-> ev_q) // R10
    else $error("data line moved off a bus clock fall");

endmodule

// ==== testbench/qwp_bus_ctrl.sv ====
`timescale 1ns/1ps
module qwp_bus_ctrl (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Extra low-phase clocks, for a slow controller
  int lag = 0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic put_bit(input logic b);
    tick(2 + lag);
    sda_low_o = !b;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask
  // Sampled just before the fall, while the target still holds
  task automatic get_bit(output logic b);
    sda_low_o = 1'b0;
    tick(4 + lag);
    scl_o = 1'b1;
    tick(4);
    b = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_low_o = 1'b0;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    sda_low_o = 1'b1;
    tick(2);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_low_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    sda_low_o = 1'b0;
    tick(4);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule

// ==== testbench/tb_quad_wiper_i2c_control.sv ====
`timescale 1ns/1ps
`include "qwp_defines.svh"
module tb_quad_wiper_i2c_control;
  import qwp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] strap = 4'h0;
  logic scl;
  logic ctrl_low;
  logic sda_w;
  logic sda_o;
  logic sda_oe_o;
  qwp_pos_bus_t pos;
  qwp_tap_bus_t tap;
  int error_cnt = 0;
  int num_checks = 0;
  int wip[4];
  int sav[16];
  always #12.5 sys_clk_i = ~sys_clk_i;
  // Pull-up wire shared by both open-drain parties
  assign sda_w = !(ctrl_low || sda_oe_o);
  qwp_quad_wiper i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .strap_address_pins_i(strap),
    .wiper_pos_o(pos), .wiper_tap_o(tap));
  qwp_bus_ctrl i_ctrl (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(ctrl_low));
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) fail("acknowledge mismatch");
  endtask
  task automatic chk_val(input logic [7:0] got, input int exp);
    num_checks++;
    if (got !== 8'(exp)) fail("read data mismatch");
  endtask
  task automatic chk_pos();
    repeat (3) @(negedge sys_clk_i);
    for (int c = 0; c < 4; c++) begin
      num_checks++;
      if (pos[6*c +: 6] !== 6'(wip[c])) fail("wiper position mismatch");
      if (tap[64*c +: 64] !== 64'h1 << wip[c]) fail("tap select mismatch");
    end
    if (sda_o !== 1'b0) fail("data line driven high");
  endtask
  function automatic logic [7:0] ins(input logic [3:0] op, input int ch, input int sl);
    return {op, 2'(ch), 2'(sl)};
  endfunction
  task automatic cmd(input logic [7:0] i, input logic [7:0] d, input bit has_d, input logic [3:0] ad);
    logic a;
    i_ctrl.start();
    i_ctrl.send_byte({`QWP_ADDR_PREFIX, ad, 1'b0}, a);
    chk_ack(a, ad == strap);
    if (ad == strap) begin
      i_ctrl.send_byte(i, a);
      chk_ack(a, 1'b1);
      if (has_d) begin
        i_ctrl.send_byte(d, a);
        chk_ack(a, 1'b1);
      end
    end
    i_ctrl.stop();
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    logic a;
    cmd(i, 8'h00, 1'b0, strap);
    i_ctrl.start();
    i_ctrl.send_byte({`QWP_ADDR_PREFIX, strap, 1'b1}, a);
    chk_ack(a, 1'b1);
    i_ctrl.recv_byte(1'b1, v);
    i_ctrl.stop();
  endtask
  // Opens a frame to this target and expects the address to be taken
  task automatic open_ok(input logic r);
    logic a;
    i_ctrl.start();
    i_ctrl.send_byte({`QWP_ADDR_PREFIX, strap, r}, a);
    chk_ack(a, 1'b1);
  endtask
  task automatic send_chk(input logic [7:0] d, input logic exp);
    logic a;
    i_ctrl.send_byte(d, a);
    chk_ack(a, exp);
  endtask
  initial begin
    #1000000;
    fail("timeout");
    give_verdict();
  end
  initial begin
    logic [7:0] v;
    int d;
    int s;
    void'($urandom(32'ha11d));
    strap = 4'($urandom);
    repeat (12) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk_pos();
    for (int c = 0; c < 4; c++) begin
      d = $urandom_range(63);
      cmd(ins(`QWP_OP_WR_WIPER, c, 0), 8'(d), 1'b1, strap);
      wip[c] = d;
      chk_pos();
      rd(ins(`QWP_OP_RD_WIPER, c, 0), v);
      chk_val(v, wip[c]);
    end
    for (int k = 0; k < 16; k++) begin
      i_ctrl.lag = k % 3;
      sav[k] = $urandom_range(63);
      cmd(ins(`QWP_OP_WR_SAVED, k / 4, k % 4), 8'(sav[k]), 1'b1, strap);
    end
    i_ctrl.lag = 0;
    for (int k = 0; k < 16; k++) begin
      rd(ins(`QWP_OP_RD_SAVED, k / 4, k % 4), v);
      chk_val(v, sav[k]);
    end
    for (int c = 0; c < 4; c++) begin
      cmd(ins(`QWP_OP_RECALL, c, c), 8'h00, 1'b0, strap);
      wip[c] = sav[4*c + c];
      chk_pos();
      d = $urandom_range(63);
      cmd(ins(`QWP_OP_WR_WIPER, c, 0), 8'(d), 1'b1, strap);
      wip[c] = d;
      s = 4*c + 3 - c;
      cmd(ins(`QWP_OP_STORE, c, 3 - c), 8'h00, 1'b0, strap);
      sav[s] = d;
      rd(ins(`QWP_OP_RD_SAVED, c, 3 - c), v);
      chk_val(v, sav[s]);
    end
    // Saturation at both ends, no wrap
    cmd(ins(`QWP_OP_WR_WIPER, 2, 0), 8'h3e, 1'b1, strap);
    wip[2] = 62;
    for (int k = 0; k < 5; k++) begin
      if (k == 2) begin
        cmd(ins(`QWP_OP_WR_WIPER, 2, 0), 8'h01, 1'b1, strap);
        wip[2] = 1;
      end
      cmd(ins(`QWP_OP_INCDEC, 2, 0), 8'(k < 2) << `QWP_STEP_UP_BIT, 1'b1, strap);
      wip[2] = (k < 2) ? ((wip[2] < 63) ? wip[2] + 1 : 63) : ((wip[2] > 0) ? wip[2] - 1 : 0);
      chk_pos();
    end
    for (int b = 0; b < 4; b++) begin
      cmd(ins(`QWP_OP_WR_WIPER, 0, 0), 8'h2a, 1'b1, strap ^ (4'h1 << b));
      chk_pos();
    end
    // Refused: undefined opcode, then a data byte after a read selection
    open_ok(1'b0);
    send_chk(8'h00, 1'b0);
    i_ctrl.stop();
    open_ok(1'b0);
    send_chk(ins(`QWP_OP_RD_WIPER, 1, 0), 1'b1);
    send_chk(8'h15, 1'b0);
    i_ctrl.stop();
    chk_pos();
    // Several steps inside one frame
    open_ok(1'b0);
    send_chk(ins(`QWP_OP_INCDEC, 1, 0), 1'b1);
    for (int k = 0; k < 2; k++) begin
      send_chk(8'h01 << `QWP_STEP_UP_BIT, 1'b1);
      wip[1] = (wip[1] < 63) ? wip[1] + 1 : 63;
    end
    i_ctrl.stop();
    chk_pos();
    // Repeated start into a two-byte read, slow controller
    i_ctrl.lag = 1;
    open_ok(1'b0);
    send_chk(ins(`QWP_OP_RD_WIPER, 3, 0), 1'b1);
    open_ok(1'b1);
    for (int k = 0; k < 2; k++) begin
      i_ctrl.recv_byte(k == 1, v);
      chk_val(v, wip[3]);
    end
    i_ctrl.stop();
    i_ctrl.lag = 0;
    give_verdict();
  end
endmodule
